/* File: rtl/mailbox_pkg.sv */
package mailbox_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int          DATA_W      = 36;         // mailbox and data bus width
    localparam int          CTRL_W      = 5;          // clock, select, direction, enable, mail

    // ****************************************
    // reset values
    // ****************************************
    localparam logic        FLAG_EMPTY  = 1'h1;       // flag high: no unread mail
    localparam logic [35:0] MAIL_RESET  = 36'h0;      // stored word after reset
    localparam logic        OE_IDLE_N   = 1'h1;       // data bus released
    localparam logic [1:0]  SYNC_RESET  = 2'h0;       // synchroniser stages after reset

    // ****************************************
    // port direction encodings
    // ****************************************
    localparam logic        A_WRITE_LVL = 1'h1;       // port A writes with direction high
    localparam logic        B_WRITE_LVL = 1'h0;       // port B writes with direction low

endpackage : mailbox_pkg

/* File: rtl/dual_port_mailbox_bypass.sv */
`timescale 1ns/1ps
// Operation
// - Two 36-bit mailboxes, one per direction, pass words outside the FIFO queues.
// - A port's mail select high aims its transfer at a mailbox, low at its FIFO.
// - A port A clock rise with a selected mailbox write loads mailbox one from port A.
// - A port B clock rise with a selected mailbox write loads mailbox two from port B.
// - A successful store drives that mailbox's flag low to show unread mail.
// - While a mailbox flag is low, further writes to it are dropped and change nothing.
// - Driven data is the FIFO word with mail select low, the mailbox word with it high.
// - A port B clock rise with a selected mailbox read raises the mailbox one flag.
// - A port A clock rise with a selected mailbox read raises the mailbox two flag.
// - Reading leaves a mailbox word intact; only an accepted write changes it.
module dual_port_mailbox_bypass
    import mailbox_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              port_a_clock,
    input  wire logic              port_a_chip_select_n,
    input  wire logic              port_a_write_not_read,
    input  wire logic              port_a_enable,
    input  wire logic              port_a_mail_select,
    input  wire logic [DATA_W-1:0] port_a_data_bus_in,
    output logic      [DATA_W-1:0] port_a_data_bus_out,
    output logic                   port_a_data_bus_oe_n,
    input  wire logic [DATA_W-1:0] port_a_fifo_word,
    input  wire logic              port_b_clock,
    input  wire logic              port_b_chip_select_n,
    input  wire logic              port_b_write_not_read,
    input  wire logic              port_b_enable,
    input  wire logic              port_b_mail_select,
    input  wire logic [DATA_W-1:0] port_b_data_bus_in,
    output logic      [DATA_W-1:0] port_b_data_bus_out,
    output logic                   port_b_data_bus_oe_n,
    input  wire logic [DATA_W-1:0] port_b_fifo_word,
    input  wire logic              fifo_one_reset_n,
    input  wire logic              fifo_two_reset_n,
    output logic                   mailbox_one_flag_n,
    output logic                   mailbox_two_flag_n
);

    localparam int PIN_W = DATA_W + CTRL_W;

    // ****************************************
    // decode helpers
    // ****************************************
    // a mailbox access: chip selected, enabled, mail select high, direction matches
    function automatic logic mail_access(input logic cs_n, input logic en, input logic sel,
                                         input logic dir, input logic want);
        mail_access = !cs_n && en && sel && (dir == want);
    endfunction : mail_access

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] a_meta_q;
    logic [PIN_W-1:0] a_sync_q;
    logic             a_clk_old_q;
    logic [PIN_W-1:0] b_meta_q;
    logic [PIN_W-1:0] b_sync_q;
    logic             b_clk_old_q;
    logic [1:0]       rst_one_q;
    logic [1:0]       rst_two_q;

    // port clocks come from the masters, so their rises are found after two flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            a_meta_q    <= '0;
            a_sync_q    <= '0;
            a_clk_old_q <= 1'h0;
        end else begin
            a_meta_q    <= {port_a_clock, port_a_chip_select_n, port_a_write_not_read,
                            port_a_enable, port_a_mail_select, port_a_data_bus_in};
            a_sync_q    <= a_meta_q;
            a_clk_old_q <= a_sync_q[PIN_W-1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            b_meta_q    <= '0;
            b_sync_q    <= '0;
            b_clk_old_q <= 1'h0;
        end else begin
            b_meta_q    <= {port_b_clock, port_b_chip_select_n, port_b_write_not_read,
                            port_b_enable, port_b_mail_select, port_b_data_bus_in};
            b_sync_q    <= b_meta_q;
            b_clk_old_q <= b_sync_q[PIN_W-1];
        end
    end

    // fifo resets are asynchronous pins too
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_one_q <= SYNC_RESET;
            rst_two_q <= SYNC_RESET;
        end else begin
            rst_one_q <= {rst_one_q[0], fifo_one_reset_n};
            rst_two_q <= {rst_two_q[0], fifo_two_reset_n};
        end
    end

    // ****************************************
    // decoded port activity
    // ****************************************
    logic              a_rise;
    logic              a_cs_n;
    logic              a_dir;
    logic              a_en;
    logic              a_sel;
    logic [DATA_W-1:0] a_data;
    logic              b_rise;
    logic              b_cs_n;
    logic              b_dir;
    logic              b_en;
    logic              b_sel;
    logic [DATA_W-1:0] b_data;
    logic              one_reset;
    logic              two_reset;
    logic              a_wr_mail;
    logic              a_rd_mail;
    logic              b_wr_mail;
    logic              b_rd_mail;
    logic              one_accept;
    logic              two_accept;

    assign {a_cs_n, a_dir, a_en, a_sel, a_data} = a_sync_q[PIN_W-2:0];
    assign {b_cs_n, b_dir, b_en, b_sel, b_data} = b_sync_q[PIN_W-2:0];
    assign a_rise    = a_sync_q[PIN_W-1] && !a_clk_old_q;
    assign b_rise    = b_sync_q[PIN_W-1] && !b_clk_old_q;
    assign one_reset = !rst_one_q[1];
    assign two_reset = !rst_two_q[1];

    // port A writes with direction high, port B with direction low
    assign a_wr_mail = a_rise
                       && mail_access(a_cs_n, a_en, a_sel, a_dir, A_WRITE_LVL);
    assign a_rd_mail = a_rise
                       && mail_access(a_cs_n, a_en, a_sel, a_dir, !A_WRITE_LVL);
    assign b_wr_mail = b_rise
                       && mail_access(b_cs_n, b_en, b_sel, b_dir, B_WRITE_LVL);
    assign b_rd_mail = b_rise
                       && mail_access(b_cs_n, b_en, b_sel, b_dir, !B_WRITE_LVL);

    // a write lands only while the flag shows the box empty
    assign one_accept = a_wr_mail && mailbox_one_flag_n && !one_reset;
    assign two_accept = b_wr_mail && mailbox_two_flag_n && !two_reset;

    // ****************************************
    // mailbox storage
    // ****************************************
    logic [DATA_W-1:0] mailbox_one_q;
    logic [DATA_W-1:0] mailbox_two_q;

    // words change only on an accepted write; reads never touch them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mailbox_one_q <= MAIL_RESET;
        end else if (one_accept) begin
            mailbox_one_q <= a_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mailbox_two_q <= MAIL_RESET;
        end else if (two_accept) begin
            mailbox_two_q <= b_data;
        end
    end

    // ****************************************
    // mail flags
    // ****************************************
    // fifo reset first; a new store beats a read on the same edge so mail is never lost
    always_ff @(posedge core_clk) begin
        if (sys_rst || one_reset) begin
            mailbox_one_flag_n <= FLAG_EMPTY;
        end else if (one_accept) begin
            mailbox_one_flag_n <= 1'h0;
        end else if (b_rd_mail) begin
            mailbox_one_flag_n <= 1'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || two_reset) begin
            mailbox_two_flag_n <= FLAG_EMPTY;
        end else if (two_accept) begin
            mailbox_two_flag_n <= 1'h0;
        end else if (a_rd_mail) begin
            mailbox_two_flag_n <= 1'h1;
        end
    end

    // ****************************************
    // data bus drivers
    // ****************************************
    // registered mux; the bus follows the pins a few core cycles late
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_a_data_bus_out  <= MAIL_RESET;
            port_a_data_bus_oe_n <= OE_IDLE_N;
        end else begin
            port_a_data_bus_out  <= a_sel ? mailbox_two_q : port_a_fifo_word;
            port_a_data_bus_oe_n <= a_cs_n || (a_dir == A_WRITE_LVL);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_b_data_bus_out  <= MAIL_RESET;
            port_b_data_bus_oe_n <= OE_IDLE_N;
        end else begin
            port_b_data_bus_out  <= b_sel ? mailbox_one_q : port_b_fifo_word;
            port_b_data_bus_oe_n <= b_cs_n || (b_dir == B_WRITE_LVL);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // a pin clock rise with a mailbox write that is then taken
    sequence s_a_store;
        a_wr_mail && mailbox_one_flag_n && !one_reset;
    endsequence

    // the same on port B, into mailbox two
    sequence s_b_store;
        b_wr_mail && mailbox_two_flag_n && !two_reset;
    endsequence

    // stored words follow the synchronised data pins
    a_one_store_word: assert property (
        s_a_store |=> mailbox_one_q == $past(a_data))
        else $error("mailbox one did not take port A data");
    a_two_store_word: assert property (
        s_b_store |=> mailbox_two_q == $past(b_data))
        else $error("mailbox two did not take port B data");

    // a taken store shows as mail on the next edge
    a_store_flag_low: assert property (
        s_a_store ##1 !one_reset |-> !mailbox_one_flag_n)
        else $error("mailbox one flag not low after store");
    a_two_flag_low: assert property (
        s_b_store |=> !mailbox_two_flag_n)
        else $error("mailbox two flag not low after store");

    // a full mailbox ignores writes, word and flag alike
    a_full_write_drop: assert property (
        a_wr_mail && !mailbox_one_flag_n |=> $stable(mailbox_one_q))
        else $error("write to full mailbox one changed it");
    a_two_write_drop: assert property (
        b_wr_mail && !mailbox_two_flag_n |=> $stable(mailbox_two_q))
        else $error("write to full mailbox two changed it");
    a_full_flag_hold: assert property (
        !mailbox_one_flag_n && !b_rd_mail && !one_reset |=> !mailbox_one_flag_n)
        else $error("mailbox one flag rose without a read");

    // the opposite port's read clears the mail indication
    a_one_read_flag: assert property (
        b_rd_mail && !one_accept && !one_reset |=> mailbox_one_flag_n)
        else $error("mailbox one flag not raised by port B read");
    a_two_read_flag: assert property (
        a_rd_mail && !two_accept && !two_reset |=> mailbox_two_flag_n)
        else $error("mailbox two flag not raised by port A read");

    // reads never disturb the stored words
    a_word_held_read: assert property (
        !one_accept |=> $stable(mailbox_one_q))
        else $error("mailbox one changed without accepted write");
    a_two_word_held: assert property (
        !two_accept |=> $stable(mailbox_two_q))
        else $error("mailbox two changed without accepted write");

    // the edge that leaves reset still loads reset values, so it starts no attempt
    a_out_source_sel: assert property (
        !sys_rst |=> port_b_data_bus_out == ($past(b_sel) ? $past(mailbox_one_q)
                                                          : $past(port_b_fifo_word)))
        else $error("port B output source wrong");
    a_a_out_source: assert property (
        !sys_rst |=> port_a_data_bus_out == ($past(a_sel) ? $past(mailbox_two_q)
                                                          : $past(port_a_fifo_word)))
        else $error("port A output source wrong");

    // a fifo reset shows no mail for its direction
    a_fifo_reset_flag: assert property (two_reset |=> mailbox_two_flag_n)
        else $error("mailbox two flag not high under fifo reset");
    a_one_reset_flag: assert property (one_reset |=> mailbox_one_flag_n)
        else $error("mailbox one flag not high under fifo reset");

    // with the enable low a pin clock rise changes neither word nor flag
    a_enable_low_hold: assert property (
        a_rise && !a_en |=> $stable(mailbox_one_q))
        else $error("mailbox one changed with port A enable low");
    a_b_enable_hold: assert property (
        b_rise && !b_en |=> $stable(mailbox_two_q))
        else $error("mailbox two changed with port B enable low");
    a_enable_flag_hold: assert property (
        b_rise && !b_en && !one_accept && !one_reset |=> $stable(mailbox_one_flag_n))
        else $error("mailbox one flag moved with port B enable low");

endmodule : dual_port_mailbox_bypass

/* File: verif/port_master.sv */
`timescale 1ns/1ps
// ****************************************
// pin-level master of one port
// ****************************************
module port_master
    import mailbox_pkg::*;
#(
    parameter logic WR_LVL = A_WRITE_LVL
) (
    input  wire logic              core_clk,
    output logic                   pin_clk,
    output logic                   cs_n,
    output logic                   wnr,
    output logic                   en,
    output logic                   sel,
    output logic      [DATA_W-1:0] data
);
    // idle pins; the pin clock stands low between transfers
    initial begin
        pin_clk = 1'h0;
        cs_n    = 1'h1;
        wnr     = ~WR_LVL;
        en      = 1'h0;
        sel     = 1'h0;
        data    = '0;
    end

    // one transfer; 4-cycle phases since the sync path needs 3
    task automatic xfer(input logic wr, input logic s, input logic e,
                        input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        cs_n <= 1'h0;
        wnr  <= wr ? WR_LVL : ~WR_LVL;
        en   <= e;
        sel  <= s;
        data <= d;
        repeat (4) @(posedge core_clk);
        pin_clk <= 1'h1;
        repeat (4) @(posedge core_clk);
        pin_clk <= 1'h0;
        repeat (4) @(posedge core_clk);
        cs_n <= 1'h1;
        data <= ~d; // released bus must not show the stale word
        repeat (4) @(posedge core_clk);
    endtask : xfer
endmodule : port_master

/* File: verif/dual_port_mailbox_bypass_tb_top.sv */
`timescale 1ns/1ps
module dual_port_mailbox_bypass_tb_top;
    import mailbox_pkg::*;
    typedef struct packed {
        logic pb; logic wr; logic s; logic e;
        logic [35:0] d; logic f1; logic f2; logic [35:0] q;
    } row_t;
    localparam logic [35:0] D1 = 36'h1_2345_6789;
    localparam logic [35:0] D2 = 36'hA_BCDE_F012;
    localparam logic [35:0] D3 = 36'h5_5AA5_5AA5;
    localparam logic [35:0] D4 = 36'hF_0F0F_0F0F;
    localparam logic [35:0] FA = 36'h3_3333_3333;
    localparam logic [35:0] FB = 36'hC_CCCC_CCCC;
    // ****************************************
    // cases: port, write, select, enable, data, flags, port output
    // ****************************************
    localparam row_t ROWS [12] = '{
        '{1'h0, 1'h1, 1'h1, 1'h1, D1, 1'h0, 1'h1, 36'h0},
        '{1'h0, 1'h1, 1'h1, 1'h1, D2, 1'h0, 1'h1, 36'h0},
        '{1'h1, 1'h0, 1'h1, 1'h1, D2, 1'h1, 1'h1, D1},
        '{1'h1, 1'h0, 1'h1, 1'h1, D2, 1'h1, 1'h1, D1},
        '{1'h0, 1'h1, 1'h1, 1'h0, D3, 1'h1, 1'h1, 36'h0},
        '{1'h0, 1'h1, 1'h0, 1'h1, D3, 1'h1, 1'h1, FA},
        '{1'h1, 1'h1, 1'h1, 1'h1, D4, 1'h1, 1'h0, D1},
        '{1'h0, 1'h0, 1'h0, 1'h1, D3, 1'h1, 1'h0, FA},
        '{1'h0, 1'h0, 1'h1, 1'h1, D3, 1'h1, 1'h1, D4},
        '{1'h0, 1'h1, 1'h1, 1'h1, D3, 1'h0, 1'h1, D4},
        '{1'h1, 1'h0, 1'h1, 1'h0, D2, 1'h0, 1'h1, D3},
        '{1'h1, 1'h0, 1'h1, 1'h1, D2, 1'h1, 1'h1, D3}};
    logic              core_clk = 1'h0;
    logic              sys_rst  = 1'h1;
    logic              fifo_one_reset_n = 1'h1;
    logic              fifo_two_reset_n = 1'h1;
    logic              ack_a, cs_a, wnr_a, en_a, sel_a, oe_a, f1;
    logic              ack_b, cs_b, wnr_b, en_b, sel_b, oe_b, f2;
    logic [DATA_W-1:0] drv_a, drv_b, out_a, out_b, din_a, din_b;
    int                error_cnt    = 0;
    int                total_checks = 0;

    always #4 core_clk = ~core_clk;
    // data pins: device drives while its enable is low
    assign din_a = oe_a ? drv_a : out_a;
    assign din_b = oe_b ? drv_b : out_b;

    port_master #(.WR_LVL(A_WRITE_LVL)) port_a_master (.core_clk(core_clk), .pin_clk(ack_a),
        .cs_n(cs_a), .wnr(wnr_a), .en(en_a), .sel(sel_a), .data(drv_a));
    port_master #(.WR_LVL(B_WRITE_LVL)) port_b_master (.core_clk(core_clk), .pin_clk(ack_b),
        .cs_n(cs_b), .wnr(wnr_b), .en(en_b), .sel(sel_b), .data(drv_b));
    dual_port_mailbox_bypass dual_port_mailbox_bypass_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .port_a_clock(ack_a), .port_a_chip_select_n(cs_a),
        .port_a_write_not_read(wnr_a), .port_a_enable(en_a), .port_a_mail_select(sel_a),
        .port_a_data_bus_in(din_a), .port_a_data_bus_out(out_a), .port_a_data_bus_oe_n(oe_a),
        .port_a_fifo_word(FA), .port_b_clock(ack_b), .port_b_chip_select_n(cs_b),
        .port_b_write_not_read(wnr_b), .port_b_enable(en_b), .port_b_mail_select(sel_b),
        .port_b_data_bus_in(din_b), .port_b_data_bus_out(out_b), .port_b_data_bus_oe_n(oe_b),
        .port_b_fifo_word(FB), .fifo_one_reset_n(fifo_one_reset_n),
        .fifo_two_reset_n(fifo_two_reset_n), .mailbox_one_flag_n(f1), .mailbox_two_flag_n(f2));

    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 12; i++) begin
            if (ROWS[i].pb) port_b_master.xfer(ROWS[i].wr, ROWS[i].s, ROWS[i].e, ROWS[i].d);
            else port_a_master.xfer(ROWS[i].wr, ROWS[i].s, ROWS[i].e, ROWS[i].d);
            check("flag_one", 36'(f1), 36'(ROWS[i].f1));
            check("flag_two", 36'(f2), 36'(ROWS[i].f2));
            check("data_out", ROWS[i].pb ? out_b : out_a, ROWS[i].q);
            check("oe_idle", 36'({oe_a, oe_b}), 36'h3);
        end
        // fifo resets force both flags high and block stores meanwhile
        port_a_master.xfer(1'h1, 1'h1, 1'h1, D1);
        port_b_master.xfer(1'h1, 1'h1, 1'h1, D2);
        check("flags", 36'({f1, f2}), 36'h0);
        fifo_one_reset_n <= 1'h0;
        fifo_two_reset_n <= 1'h0;
        repeat (6) @(posedge core_clk);
        check("flags", 36'({f1, f2}), 36'h3);
        port_a_master.xfer(1'h1, 1'h1, 1'h1, D2);
        check("flag_one", 36'(f1), 36'h1);
        fifo_one_reset_n <= 1'h1;
        fifo_two_reset_n <= 1'h1;
        // mid-transfer the read drives the bus from mailbox one
        fork
            port_b_master.xfer(1'h0, 1'h1, 1'h1, D2);
            begin
                repeat (10) @(posedge core_clk);
                check("oe_drive", 36'(oe_b), 36'h0);
                check("data_out", out_b, D1);
            end
        join
        check("data_out", out_b, D1);
        // reset in mid-run with unread mail pending
        port_b_master.xfer(1'h1, 1'h1, 1'h1, D4);
        check("flag_two", 36'(f2), 36'h0);
        sys_rst <= 1'h1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'h0;
        repeat (6) @(posedge core_clk);
        check("flags", 36'({f1, f2}), 36'h3);
        check("data_out", out_a, 36'h0);
        check("data_out", out_b, 36'h0);
        complete_run();
    end
endmodule : dual_port_mailbox_bypass_tb_top
